/* File: include/sck_pkg.sv */
// package: command codes, states, timing constants of the command and clock-enable logic
`default_nettype none
package sck_pkg;
  // command code is {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_NOP       = 4'h7;

  localparam int NUM_BANKS          = 8;
  localparam int AP_BIT             = 10;
  // times in clock cycles
  localparam int SR_EXIT_READ_CLKS  = 200;
  localparam int SR_EXIT_NONRD_CLKS = 2;
  localparam int MODE_LOAD_GAP_CLKS = 2;
  localparam int PRECHARGE_CLKS     = 5;
  localparam int BURST_CLKS         = 4;
  localparam int CNT_W              = 8;
  localparam logic [7:0] BANKS_RST  = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACTIVE, ST_PD_ACT, ST_PD_PRE, ST_SELF_REF
  } sck_pwr_t;

  // one decoded command
  typedef struct packed {
    logic        cke;
    logic [3:0]  cmd;
    logic [2:0]  bank;
    logic [13:0] addr;
  } sck_cmd_t;
endpackage
`default_nettype wire

/* File: src/sck_core.sv */
// module: clock-enable states, bank tracking and command acceptance of the memory die
`default_nettype none
// ------------------------------------------------------------
// What this block does
// - power-down exit: clock-enable rises with NOP/DESELECT
// - self-refresh exit: clock-enable rises, NOP/DESELECT
// - refresh with clock-enable falling enters self-refresh
// - fall with NOP: active or precharge power-down
// - no refresh performed during power-down
// - no termination in self-refresh
// - mask high leaves byte unchanged
// - chip select high accepts no command
// - all strobes high is no-operation
// - bank address selects mode register written
// - activate opens row until precharged
// - read burst, A10 gives auto precharge
// - write burst, A10 gives auto precharge
// - read/write delayed by additive latency
// - precharge closes banks, idle after period
// - precharge to idle bank accepted, restarts period
// - refresh internal, address ignored
// - commands decoded at rising clock edge
// - self-refresh exit seen at a rising clock edge
// ------------------------------------------------------------
module sck_core
  import sck_pkg::*;
#(
  parameter int MAX_AL = 6
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // command pins
  input  wire logic        i_cke,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [2:0]  i_bank,
  input  wire logic [13:0] i_addr,
  // configuration and data qualifiers
  input  wire logic [2:0]  i_additive_latency,
  input  wire logic        i_termination_control,
  input  wire logic        i_write_byte_mask,
  input  wire logic        i_write_data_valid,
  // status
  output logic [2:0]       o_pwr_state,
  output logic [7:0]       o_bank_open,
  output logic [7:0]       o_bank_precharging,
  output logic             o_termination_on,
  output logic             o_byte_write,
  output logic             o_refresh_pulse,
  output logic             o_mode_load,
  output logic [2:0]       o_mode_sel,
  output logic             o_access_pulse,
  output logic             o_access_is_write,
  output logic             o_access_auto_pre,
  output logic [2:0]       o_access_bank,
  output logic [9:0]       o_access_col,
  output logic             o_busy,
  output logic             o_read_ok
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    sck_pwr_t                          pwr;
    logic                              cke_prev;
    logic [NUM_BANKS-1:0]              open;
    logic [NUM_BANKS-1:0]              prech;
    logic [NUM_BANKS-1:0][CNT_W-1:0]   pre_cnt;
    logic [NUM_BANKS-1:0][CNT_W-1:0]   burst_cnt;
    logic [NUM_BANKS-1:0]              auto_pre;
    logic [MAX_AL:0]                   al_vld;
    logic [MAX_AL:0][14:0]             al_info;
    logic [CNT_W-1:0]                  mrd_cnt;
    logic [CNT_W-1:0]                  sr_cnt;
    logic                              term_on;
    logic                              byte_wr;
    logic                              ref_p;
    logic                              ml;
    logic [2:0]                        ml_sel;
    logic                              acc_p;
    logic                              acc_wr;
    logic                              acc_ap;
    logic [2:0]                        acc_bank;
    logic [9:0]                        acc_col;
    logic                              busy;
    logic                              rd_ok;
  } sck_state_t;

  sck_state_t st_ff;
  sck_state_t nxt_st;
  sck_cmd_t   c;

  function automatic logic is_quiet(input logic [3:0] cmd);
    is_quiet = cmd[3] || (cmd == CMD_NOP);
  endfunction

  // one driver for the whole command word
  assign c = {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank, i_addr};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic all_idle;
    logic quiet;
    logic exec;
    logic emit;
    logic [14:0] slot;
    logic [14:0] entry;
    all_idle = 1'b0;
    quiet    = 1'b0;
    exec     = 1'b0;
    emit     = 1'b0;
    slot     = '0;
    entry    = '0;
    nxt_st   = st_ff;
    nxt_st.ref_p    = 1'b0;
    nxt_st.ml       = 1'b0;
    nxt_st.acc_p    = 1'b0;
    nxt_st.byte_wr  = 1'b0;
    nxt_st.cke_prev = c.cke;
    all_idle = (st_ff.open == '0);
    // deselect accepts nothing; nop does nothing
    quiet = is_quiet(c.cmd);
    // command taken on this edge with both clock-enable samples high
    exec  = st_ff.cke_prev && c.cke && !quiet;

    // per-bank timers keep running under deselect and nop
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (st_ff.pre_cnt[b] != '0) begin
        nxt_st.pre_cnt[b] = st_ff.pre_cnt[b] - CNT_W'(1);
        // period ends as the timer reaches zero
        nxt_st.prech[b]   = (st_ff.pre_cnt[b] != CNT_W'(1));
      end else begin
        nxt_st.prech[b] = 1'b0;
      end
      if (st_ff.burst_cnt[b] != '0) begin
        nxt_st.burst_cnt[b] = st_ff.burst_cnt[b] - CNT_W'(1);
        // auto precharge when the burst ends
        if (st_ff.burst_cnt[b] == CNT_W'(1) && st_ff.auto_pre[b]) begin
          nxt_st.open[b]     = 1'b0;
          nxt_st.prech[b]    = 1'b1;
          nxt_st.auto_pre[b] = 1'b0;
          nxt_st.pre_cnt[b]  = CNT_W'(PRECHARGE_CLKS);
        end
      end
    end
    if (st_ff.mrd_cnt != '0) begin
      nxt_st.mrd_cnt = st_ff.mrd_cnt - CNT_W'(1);
    end
    if (st_ff.sr_cnt != '0) begin
      nxt_st.sr_cnt = st_ff.sr_cnt - CNT_W'(1);
    end

    // additive latency pipe: slot 0 is internal registration
    nxt_st.al_vld  = {1'b0, st_ff.al_vld[MAX_AL:1]};
    nxt_st.al_info = {15'h0000, st_ff.al_info[MAX_AL:1]};
    if (st_ff.al_vld[0]) begin
      emit = 1'b1;
      slot = st_ff.al_info[0];
    end

    case (st_ff.pwr)
      ST_IDLE, ST_ACTIVE: begin
        if (st_ff.cke_prev && !c.cke) begin
          // refresh with falling clock-enable enters self-refresh
          if (c.cmd == CMD_REFRESH && all_idle) begin
            nxt_st.pwr = ST_SELF_REF;
          end else if (quiet) begin
            nxt_st.pwr = all_idle ? ST_PD_PRE : ST_PD_ACT;
          end
        end else if (exec) begin
          case (c.cmd)
            CMD_MODE_LOAD: begin
              // bank address picks the mode register
              if (all_idle && st_ff.mrd_cnt == '0) begin
                nxt_st.ml      = 1'b1;
                nxt_st.ml_sel  = c.bank;
                nxt_st.mrd_cnt = CNT_W'(MODE_LOAD_GAP_CLKS);
              end
            end
            CMD_REFRESH: begin
              if (all_idle) begin
                nxt_st.ref_p = 1'b1;
              end
            end
            CMD_ACTIVATE: begin
              // row opens until that bank is precharged
              if (!st_ff.open[c.bank] && !st_ff.prech[c.bank]) begin
                nxt_st.open[c.bank] = 1'b1;
              end
            end
            CMD_PRECHARGE: begin
              // one bank or all; idle bank accepted, period restarts
              for (int b = 0; b < NUM_BANKS; b++) begin
                if (c.addr[AP_BIT] || c.bank == 3'(b)) begin
                  nxt_st.open[b]     = 1'b0;
                  nxt_st.prech[b]    = 1'b1;
                  nxt_st.auto_pre[b] = 1'b0;
                  nxt_st.pre_cnt[b]  = CNT_W'(PRECHARGE_CLKS);
                end
              end
            end
            CMD_READ, CMD_WRITE: begin
              // burst on open row, A10 requests auto precharge
              if (st_ff.open[c.bank]) begin
                nxt_st.burst_cnt[c.bank] = CNT_W'(BURST_CLKS) + CNT_W'(i_additive_latency);
                nxt_st.auto_pre[c.bank]  = c.addr[AP_BIT];
                entry = {c.cmd == CMD_WRITE, c.bank, c.addr[AP_BIT:0]};
                // zero latency registers the access on this edge
                if (i_additive_latency == 3'h0) begin
                  emit = 1'b1;
                  slot = entry;
                end
                for (int k = 0; k < MAX_AL; k++) begin
                  if (k + 1 == int'(i_additive_latency)) begin
                    nxt_st.al_vld[k]  = 1'b1;
                    nxt_st.al_info[k] = entry;
                  end
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_PD_ACT, ST_PD_PRE: begin
        // stays low: hold power-down, no refresh
        if (c.cke && quiet) begin
          nxt_st.pwr = (st_ff.open == '0) ? ST_IDLE : ST_ACTIVE;
        end
      end
      ST_SELF_REF: begin
        // clock-enable high with NOP/DESELECT ends self-refresh
        if (c.cke && quiet) begin
          nxt_st.pwr    = ST_IDLE;
          nxt_st.sr_cnt = CNT_W'(SR_EXIT_READ_CLKS);
        end
      end
      default: begin
        nxt_st.pwr = ST_IDLE;
      end
    endcase
    if (nxt_st.pwr == ST_IDLE && nxt_st.open != '0) begin
      nxt_st.pwr = ST_ACTIVE;
    end else if (nxt_st.pwr == ST_ACTIVE && nxt_st.open == '0) begin
      nxt_st.pwr = ST_IDLE;
    end

    // internal registration of a read or write
    if (emit) begin
      nxt_st.acc_p    = 1'b1;
      nxt_st.acc_wr   = slot[14];
      nxt_st.acc_bank = slot[13:11];
      nxt_st.acc_ap   = slot[AP_BIT];
      nxt_st.acc_col  = slot[9:0];
    end
    nxt_st.busy  = (nxt_st.burst_cnt != '0) || (nxt_st.mrd_cnt != '0)
                   || (nxt_st.prech != '0);
    nxt_st.rd_ok = (nxt_st.sr_cnt == '0);

    nxt_st.term_on = i_termination_control && (nxt_st.pwr != ST_SELF_REF);
    nxt_st.byte_wr = i_write_data_valid && !i_write_byte_mask;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff      <= '0;
      st_ff.pwr  <= ST_IDLE;
      st_ff.open <= BANKS_RST;
      st_ff.rd_ok <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_pwr_state        = st_ff.pwr;
  assign o_bank_open        = st_ff.open;
  assign o_bank_precharging = st_ff.prech;
  assign o_termination_on   = st_ff.term_on;
  assign o_byte_write       = st_ff.byte_wr;
  assign o_refresh_pulse    = st_ff.ref_p;
  assign o_mode_load        = st_ff.ml;
  assign o_mode_sel         = st_ff.ml_sel;
  assign o_access_pulse     = st_ff.acc_p;
  assign o_access_is_write  = st_ff.acc_wr;
  assign o_access_auto_pre  = st_ff.acc_ap;
  assign o_access_bank      = st_ff.acc_bank;
  assign o_access_col       = st_ff.acc_col;
  assign o_busy             = st_ff.busy;
  assign o_read_ok          = st_ff.rd_ok;

endmodule // sck_core
`default_nettype wire

/* File: verif/sck_ctrl_model.sv */
// partner: controller model that drives the command pins
`default_nettype none
module sck_ctrl_model
  import sck_pkg::*;
(
  // clock and reset
  input  wire logic     i_mclk,
  input  wire logic     i_sys_rst,
  // requested and driven command
  input  wire sck_cmd_t i_req,
  output var sck_cmd_t  o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hold_ff;
  logic       cke_ff;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_ff <= 2'h0;
      cke_ff  <= 1'b0;
    end else begin
      cke_ff  <= o_pin.cke;
      hold_ff <= (o_pin.cke != cke_ff) ? 2'h0 : ((hold_ff == 2'h2) ? 2'h2 : hold_ff + 2'h1);
    end
  end
  always_comb begin
    o_pin = i_req;
    if (hold_ff != 2'h2) o_pin.cke = cke_ff;
    if (o_pin.cke != cke_ff && !(i_req.cmd == CMD_REFRESH && !o_pin.cke)) o_pin.cmd = CMD_NOP;
  end
endmodule // sck_ctrl_model
`default_nettype wire

/* File: verif/sck_core_monitor.sv */
// checker: power states and command acceptance of the core
`default_nettype none
module sck_core_monitor
  import sck_pkg::*;
(
  // pins and configuration
  input wire logic       i_mclk, i_sys_rst, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
  input wire logic [2:0] i_bank, i_additive_latency,
  input wire logic       i_write_byte_mask, i_write_data_valid,
  // status
  input wire logic [2:0] o_pwr_state,
  input wire logic [7:0] o_bank_open,
  input wire logic       o_busy, o_termination_on, o_byte_write, o_refresh_pulse,
  input wire logic       o_mode_load, o_access_pulse, o_read_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cke_q_ff;
  wire logic [3:0] cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  wire logic quiet = i_cs_n | (cmd == CMD_NOP);
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) cke_q_ff <= 1'b0;
    else cke_q_ff <= i_cke;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_sr_entry: assert property (
    cke_q_ff && !i_cke && cmd == CMD_REFRESH && o_bank_open == 8'h00 && !o_busy
    && o_pwr_state == 3'h0 |=> o_pwr_state == 3'h4) else $error("no self refresh");
  a_pd_precharge: assert property (
    cke_q_ff && !i_cke && quiet && o_bank_open == 8'h00 && !o_busy && o_pwr_state == 3'h0
    |=> o_pwr_state == 3'h3) else $error("no precharge power-down");
  a_pd_stay: assert property (
    (o_pwr_state == 3'h2 || o_pwr_state == 3'h3) && !i_cke
    |=> $stable(o_pwr_state) && !o_refresh_pulse) else $error("power-down left");
  a_sr_exit: assert property (
    o_pwr_state == 3'h4 && i_cke && quiet
    |=> (o_pwr_state == 3'h0 && !o_read_ok) ##1 !o_read_ok [*7]) else $error("bad exit");
  a_sr_no_term: assert property (
    o_pwr_state == 3'h4 && !i_cke |=> o_pwr_state == 3'h4 && !o_termination_on)
    else $error("termination in self refresh");
  a_quiet_cmd: assert property (
    cke_q_ff && i_cke && quiet |=> !o_refresh_pulse && !o_mode_load
    && (o_bank_open & ~$past(o_bank_open)) == 8'h00) else $error("quiet cycle acted");
  a_mask_gate: assert property (
    i_write_data_valid |=> o_byte_write == !$past(i_write_byte_mask)) else $error("mask");
  a_access_now: assert property (
    cke_q_ff && i_cke && (cmd == CMD_READ || cmd == CMD_WRITE) && o_bank_open[i_bank]
    && i_additive_latency == 3'h0 |=> o_access_pulse) else $error("access late");
endmodule // sck_core_monitor
`default_nettype wire

/* File: verif/sck_core_tb.sv */
// testbench: random and corner command sequences for the core
`default_nettype none
module sck_core_tb
  import sck_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_mclk = 1'b0, i_sys_rst = 1'b1, termination_control = 1'b0, mask = 1'b0, dv = 1'b0, wr;
  logic [2:0] al = 3'h0, st, acc_bank, msel, b;
  logic [7:0] bopen, bpre;
  logic [9:0] acc_col;
  logic [13:0] a;
  logic       term_on, bw, refp, mload, accp, acc_wr, acc_ap, busy, rd_ok;
  sck_cmd_t   req = '{1'b0, CMD_NOP, 3'h0, 14'h0};
  sck_cmd_t   pin;
  int         errors = 0, checks_done = 0, n;
  always #25 i_mclk = ~i_mclk;
  sck_ctrl_model u_ctrl (.i_mclk, .i_sys_rst, .i_req(req), .o_pin(pin));
  sck_core u_dut (.i_mclk, .i_sys_rst, .i_cke(pin.cke), .i_cs_n(pin.cmd[3]),
    .i_ras_n(pin.cmd[2]), .i_cas_n(pin.cmd[1]), .i_we_n(pin.cmd[0]), .i_bank(pin.bank),
    .i_addr(pin.addr), .i_additive_latency(al), .i_termination_control(termination_control),
    .i_write_byte_mask(mask), .i_write_data_valid(dv), .o_pwr_state(st), .o_bank_open(bopen),
    .o_bank_precharging(bpre), .o_termination_on(term_on), .o_byte_write(bw),
    .o_refresh_pulse(refp), .o_mode_load(mload), .o_mode_sel(msel), .o_access_pulse(accp),
    .o_access_is_write(acc_wr), .o_access_auto_pre(acc_ap), .o_access_bank(acc_bank),
    .o_access_col(acc_col), .o_busy(busy), .o_read_ok(rd_ok));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic cmd(input logic cke, input logic [3:0] c, input logic [2:0] bk,
                     input logic [13:0] ad);
    @(negedge i_mclk);
    req = '{cke, c, bk, ad};
    // termination input at a defined level
    termination_control = 1'($urandom);
    @(posedge i_mclk);
    #1;
  endtask
  task automatic nops(input logic cke, input int k);
    repeat (k) cmd(cke, CMD_NOP, 3'($urandom), 14'($urandom));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(46063));
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk) i_sys_rst = 1'b0;
    // enable kept high through commands, no calibration
    nops(1'b1, 3);
    for (int k = 0; k < NUM_BANKS; k++) begin
      cmd(1'b1, CMD_ACTIVATE, 3'(k), 14'($urandom));
      chk("bank_open", 16'h1, 16'(bopen[k]));
    end
    repeat (8) begin
      cmd(1'b1, 4'h8 | 4'($urandom), 3'($urandom), 14'($urandom));
      chk("deselect", 16'h00FF, 16'({refp, mload, bopen}));
      chk("termination", 16'(termination_control), 16'(term_on));
    end
    $display("test activate done");
    cmd(1'b1, CMD_WRITE, 3'h1, 14'h0);
    repeat (4) begin
      @(negedge i_mclk);
      dv = 1'b1;
      mask = 1'($urandom);
      req.cmd = CMD_NOP;
      @(posedge i_mclk);
      #1;
      chk("byte_write", 16'(!mask), 16'(bw));
    end
    @(negedge i_mclk) dv = 1'b0;
    for (int k = 0; k < 7; k++) begin
      // last command must not stand again while the latency changes
      @(negedge i_mclk);
      req.cmd = CMD_NOP;
      al = 3'(k);
      a = {3'($urandom), k == 6, 10'($urandom)};
      b = 3'($urandom);
      wr = k[0];
      cmd(1'b1, wr ? CMD_WRITE : CMD_READ, b, a);
      nops(1'b1, k);
      chk("access_pulse", 16'h1, 16'(accp));
      chk("access", 16'({wr, a[10], b, a[9:0]}), 16'({acc_wr, acc_ap, acc_bank, acc_col}));
    end
    @(negedge i_mclk) al = 3'h0;
    cmd(1'b1, CMD_PRECHARGE, 3'h0, 14'h0400);
    chk("precharge_all", 16'h00FF, 16'({bopen, bpre}));
    nops(1'b1, 1);
    cmd(1'b1, CMD_ACTIVATE, 3'h0, 14'h0);
    chk("activate_precharging", 16'h0, 16'(bopen));
    cmd(1'b1, CMD_PRECHARGE, 3'h0, 14'h0);
    nops(1'b1, 4);
    chk("precharge_restart", 16'h0001, 16'(bpre));
    nops(1'b1, 1);
    chk("precharge_done", 16'h0, 16'(bpre));
    cmd(1'b1, CMD_REFRESH, 3'($urandom), 14'($urandom));
    chk("refresh", 16'h1, 16'(refp));
    b = 3'($urandom);
    cmd(1'b1, CMD_MODE_LOAD, b, 14'($urandom));
    chk("mode_load", 16'({1'b1, b}), 16'({mload, msel}));
    chk("mode_busy", 16'h1, 16'(busy));
    cmd(1'b1, CMD_MODE_LOAD, ~b, 14'h0);
    chk("mode_gap", 16'({1'b0, b}), 16'({mload, msel}));
    $display("test commands done");
    nops(1'b1, 3);
    cmd(1'b1, CMD_ACTIVATE, 3'h2, 14'h0);
    nops(1'b1, 2);
    cmd(1'b0, CMD_NOP, 3'h0, 14'h0);
    chk("active_pd", 16'h2, 16'(st));
    repeat (4) cmd(1'b0, 4'($urandom), 3'($urandom), 14'($urandom));
    chk("pd_hold", 16'h2, 16'({refp, st}));
    cmd(1'b1, CMD_NOP, 3'h0, 14'h0);
    chk("pd_exit", 16'h1, 16'(st));
    nops(1'b1, 2);
    cmd(1'b1, CMD_PRECHARGE, 3'h2, 14'h0);
    nops(1'b1, 6);
    chk("idle_before_pd", 16'h0, 16'(busy));
    cmd(1'b0, CMD_NOP, 3'h0, 14'h0);
    chk("precharge_pd", 16'h3, 16'(st));
    nops(1'b0, 3);
    nops(1'b1, 3);
    $display("test power-down done");
    cmd(1'b0, CMD_REFRESH, 3'($urandom), 14'($urandom));
    chk("self_refresh", 16'h4, 16'(st));
    repeat (4) cmd(1'b0, 4'($urandom), 3'($urandom), 14'($urandom));
    chk("sr_termination", 16'h4, 16'({term_on, st}));
    cmd(1'b1, CMD_NOP, 3'h0, 14'h0);
    chk("sr_exit", 16'h0, 16'({rd_ok, st}));
    n = 1;
    while (rd_ok !== 1'b1 && n < 400) begin
      nops(1'b1, 1);
      n++;
    end
    if (n >= 400) begin
      errors++;
      conclude();
    end
    chk("read_delay", 16'h1, 16'(n >= 200 && n <= 202));
    $display("test self refresh done");
    conclude();
  end
endmodule // sck_core_tb
bind sck_core sck_core_monitor u_mon (.i_mclk, .i_sys_rst, .i_cke, .i_cs_n, .i_ras_n,
  .i_cas_n, .i_we_n, .i_bank, .i_additive_latency, .i_write_byte_mask, .i_write_data_valid,
  .o_pwr_state, .o_bank_open, .o_busy, .o_termination_on, .o_byte_write, .o_refresh_pulse,
  .o_mode_load, .o_access_pulse, .o_read_ok);
`default_nettype wire
